// ---- i2c_port_pkg.sv ----
// Constants shared by the two-wire slave port and its bus-master end.
// Assumes both ends run on pclk at 200 MHz with asynchronous active-low reset.
//
// How it works
// - Claim only address 0011 000.
// - Device is slave only, never drives clock.
// - SDA open-drain: pull low or release.
// - Change SDA on low SCL, sample on high.
// - SDA falling while SCL high is START.
// - Master sends seven-bit address plus direction.
// - Eight-bit bytes, each followed by acknowledge.
// - Device pulls SDA low to acknowledge bytes.
// - Device drives read data; master acknowledges.
// - Master not-acknowledge ends device read output.
// - START while busy is a repeated START.
// - After STOP wait for new START.
// - General call acknowledged only when enabled.
// - Pointer increments after each written byte.
// - Master acknowledge on read increments pointer.
// - Writable registers read back; status ignores writes.
// - Eight-bit registers, 128 per page.
// - Page 0 after reset; register 0 selects page.
// - Page select holds full eight-bit page.
// - Host touches only non-reserved pages.
// - Host writes reset values into reserved bits.
// - Register 1 bit 0 self-clearing control reset.
package i2c_port_pkg;
  // ----------------------------------------------------------------
  // Link constants
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h18;
  localparam logic [6:0] GCALL_ADDR = 7'h00;
  localparam int REGS_PER_PAGE = 128;
  localparam int PAGE_W = 8;
  // Device registers
  localparam logic [6:0] REG_PAGE = 7'h00;
  localparam logic [6:0] REG_SWRST = 7'h01;
  localparam logic [6:0] REG_GCALL = 7'h22;
  localparam int GCALL_BIT = 5;
  localparam int SWRST_BIT = 0;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  // Master SCL half period: 200 MHz / 64 = 3.125 MHz link clock
  localparam int HALF_PERIOD = 32;
  // ----------------------------------------------------------------
  // Master command registers (APB byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_TXDATA = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_RXDATA = 12'h00C;
  // Command codes written into CTRL bits 2:0
  typedef enum logic [2:0] {
    CMD_NONE, CMD_START, CMD_STOP, CMD_WRITE, CMD_READ_ACK, CMD_READ_NACK
  } cmd_t;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
endpackage

// ---- i2c_link_if.sv ----
// Two-wire link joining the master end and the slave end.
// Assumes both drivers are open-drain; pull-ups are modelled here.
`timescale 1ns/1ps
interface i2c_link_if;
  logic scl_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Wired-AND with pull-ups: any enable pulls the line low
  assign scl = ~scl_oe;
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport master (output scl_oe, output sda_m_oe, input scl, input sda);
  modport slave (output sda_s_oe, input scl, input sda);
endinterface

// ---- i2c_paged_slave.sv ----
// Slave end of the two-wire control port with a paged 8-bit register bank.
// Assumes SCL and SDA arrive asynchronously; pclk is far faster than SCL.
// Line events are seen about three pclk cycles after the pins move.
//
// Chosen here: one register bank shared by every page.
`timescale 1ns/1ps
module i2c_paged_slave
  import i2c_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  i2c_link_if.slave link,
  output logic [7:0] page_q,
  output logic soft_reset_pulse_q,
  output logic gcall_en_q
);
  import i2c_port_pkg::*;

  // Byte phases: address, pointer, write data, read data, each with ack
  typedef enum {S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_WDATA, S_W_ACK, S_RDATA,
    S_R_ACK} state_t;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_q, sda_sync_q;
  logic scl_q, sda_q;
  // Two flops against metastability, a third for edge detection and SDA sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], link.scl};
      sda_sync_q <= {sda_sync_q[0], link.sda};
      scl_q <= scl_sync_q[1];
      sda_q <= sda_sync_q[1];
    end
  end

  // Line events, taken from synchronised copies only
  wire scl_rise = scl_sync_q[1] & ~scl_q;
  wire scl_fall = ~scl_sync_q[1] & scl_q;
  wire start_ev = scl_sync_q[1] & scl_q & sda_q & ~sda_sync_q[1];
  wire stop_ev = scl_sync_q[1] & scl_q & ~sda_q & sda_sync_q[1];

  // ----------------------------------------------------------------
  // Register bank: one page of 128 bytes, flip-flop storage
  // ----------------------------------------------------------------
  // A single shared bank keeps area low; page_q still tracks the page.
  logic [7:0] regs_q [REGS_PER_PAGE];
  state_t state_q;
  logic [7:0] shift_q;
  logic [3:0] bit_q;
  logic [6:0] ptr_q;
  logic rw_q, sda_oe_q, ack_ok_q;

  // Frame decode
  wire addr_hit = shift_q[7:1] == SLAVE_ADDR;
  wire gcall_hit = shift_q[7:1] == GCALL_ADDR && gcall_en_q;
  // Register 1 is never stored, so it always reads back as zero
  wire [7:0] rd_byte = ptr_q == REG_PAGE ? page_q : regs_q[ptr_q];
  wire byte_done = bit_q == 4'd8;
  wire wr_strobe = state_q == S_WDATA && scl_fall && byte_done;

  // Register writes; a software reset clears the bank, not the page
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < REGS_PER_PAGE; i++) begin
        regs_q[i] <= REG_RST;
      end
      page_q <= PAGE_RST;
      soft_reset_pulse_q <= 1'b0;
    end else begin
      soft_reset_pulse_q <= 1'b0;
      if (wr_strobe) begin
        if (ptr_q == REG_PAGE) begin
          page_q <= shift_q;
        end else if (ptr_q == REG_SWRST) begin
          if (shift_q[SWRST_BIT]) begin
            soft_reset_pulse_q <= 1'b1;
            for (int i = 0; i < REGS_PER_PAGE; i++) begin
              regs_q[i] <= REG_RST;
            end
          end
        end else begin
          regs_q[ptr_q] <= shift_q;
        end
      end
    end
  end

  // Registered so the enable is a clean level, one cycle late
  // General-call enable mirrors its page 0 bit only while page 0 is selected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gcall_en_q <= 1'b0;
    end else begin
      gcall_en_q <= page_q == PAGE_RST && regs_q[REG_GCALL][GCALL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  // SDA is only ever pulled low or released; SCL is never driven.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      shift_q <= 8'h00;
      bit_q <= 4'd0;
      ptr_q <= 7'd0;
      rw_q <= 1'b0;
      sda_oe_q <= 1'b0;
      ack_ok_q <= 1'b0;
    end else if (start_ev) begin
      state_q <= S_ADDR;
      bit_q <= 4'd0;
      sda_oe_q <= 1'b0;
    end else if (stop_ev) begin
      state_q <= S_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: sda_oe_q <= 1'b0;
        // Shift in MSB first; act on the fall after the eighth bit
        S_ADDR, S_PTR, S_WDATA: begin
          if (scl_rise && !byte_done) begin
            shift_q <= {shift_q[6:0], sda_q};
            bit_q <= bit_q + 4'd1;
          end else if (scl_fall && byte_done) begin
            bit_q <= 4'd0;
            if (state_q == S_ADDR) begin
              if (addr_hit || gcall_hit) begin
                rw_q <= shift_q[0];
                sda_oe_q <= 1'b1;
                state_q <= S_ADDR_ACK;
              end else begin
                state_q <= S_IDLE;
              end
            end else begin
              if (state_q == S_PTR) begin
                ptr_q <= shift_q[6:0];
              end else begin
                ptr_q <= ptr_q + 7'd1;
              end
              sda_oe_q <= 1'b1;
              state_q <= S_W_ACK;
            end
          end
        end
        // Acknowledge ends on the fall; reads put out their first bit here
        S_ADDR_ACK, S_W_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              sda_oe_q <= ~rd_byte[7];
              shift_q <= {rd_byte[6:0], 1'b0};
              bit_q <= 4'd1;
              state_q <= S_RDATA;
            end else begin
              sda_oe_q <= 1'b0;
              state_q <= state_q == S_ADDR_ACK ? S_PTR : S_WDATA;
            end
          end
        end
        // Next bit goes out on each fall, while SCL is low
        S_RDATA: begin
          if (scl_fall) begin
            if (byte_done) begin
              sda_oe_q <= 1'b0;
              state_q <= S_R_ACK;
            end else begin
              sda_oe_q <= ~shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
              bit_q <= bit_q + 4'd1;
            end
          end
        end
        // Pointer moves at the sample so the next byte is ready by the fall
        S_R_ACK: begin
          if (scl_rise) begin
            ack_ok_q <= ~sda_q;
            if (!sda_q) begin
              ptr_q <= ptr_q + 7'd1;
            end
          end else if (scl_fall) begin
            if (ack_ok_q) begin
              sda_oe_q <= ~rd_byte[7];
              shift_q <= {rd_byte[6:0], 1'b0};
              bit_q <= 4'd1;
              state_q <= S_RDATA;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Enable only pulls low; the pull-up supplies every high level
  assign link.sda_s_oe = sda_oe_q;
endmodule

// ---- i2c_bus_master.sv ----
// Master end: APB-programmed byte engine that drives the two-wire link.
// Assumes an APB master on pclk; SCL is derived here by a divider.
`timescale 1ns/1ps
module i2c_bus_master
  import i2c_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  i2c_link_if.master link
);
  import i2c_port_pkg::*;

  typedef enum {M_IDLE, M_START, M_BIT, M_STOP} mstate_t;

  // ----------------------------------------------------------------
  // Input synchroniser on SDA
  // ----------------------------------------------------------------
  logic [1:0] sda_sync_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sda_sync_q <= 2'b11;
    else sda_sync_q <= {sda_sync_q[0], link.sda};
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  mstate_t st_q;
  cmd_t cmd_q;
  logic [7:0] tx_q, rx_q;
  logic nack_q, busy_q, scl_oe_q, sda_oe_q;
  logic [5:0] cnt_q;
  logic [1:0] phase_q;
  logic [3:0] bit_q;

  wire acc = psel & penable;
  wire hit_ctrl = paddr == OFF_CTRL;
  wire hit_tx = paddr == OFF_TXDATA;
  wire hit_st = paddr == OFF_STATUS;
  wire hit_rx = paddr == OFF_RXDATA;
  wire cmd_wr = acc & pwrite & hit_ctrl & ~busy_q;
  wire [31:0] rd_mux = hit_st ? {30'd0, nack_q, busy_q} :
    hit_rx ? {24'd0, rx_q} : hit_tx ? {24'd0, tx_q} : 32'h0000_0000;

  // Zero-wait answer; unmapped offsets error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      prdata <= rd_mux;
      pslverr <= psel & ~penable & ~(hit_ctrl | hit_tx | hit_st | hit_rx);
    end
  end

  // ----------------------------------------------------------------
  // Link engine: four phases per bit, each HALF_PERIOD/2 cycles
  // ----------------------------------------------------------------
  wire tick = cnt_q == 6'(HALF_PERIOD / 2 - 1);
  wire rd_cmd = cmd_q == CMD_READ_ACK || cmd_q == CMD_READ_NACK;
  // Bit 8 is the acknowledge slot
  wire out_bit = bit_q == 4'd8 ? (cmd_q == CMD_READ_ACK ? 1'b0 :
    cmd_q == CMD_READ_NACK ? 1'b1 : 1'b1) : (rd_cmd ? 1'b1 : tx_q[7 - bit_q[2:0]]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= M_IDLE;
      cmd_q <= CMD_NONE;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      nack_q <= 1'b0;
      busy_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      cnt_q <= 6'd0;
      phase_q <= 2'd0;
      bit_q <= 4'd0;
    end else begin
      if (acc & pwrite & hit_tx & ~busy_q) tx_q <= pwdata[7:0];
      cnt_q <= tick ? 6'd0 : cnt_q + 6'd1;
      if (cmd_wr) begin
        cmd_q <= cmd_t'(pwdata[2:0]);
        busy_q <= 1'b1;
        phase_q <= 2'd0;
        bit_q <= 4'd0;
        cnt_q <= 6'd0;
        case (cmd_t'(pwdata[2:0]))
          CMD_START: st_q <= M_START;
          CMD_STOP: st_q <= M_STOP;
          CMD_WRITE, CMD_READ_ACK, CMD_READ_NACK: st_q <= M_BIT;
          default: busy_q <= 1'b0;
        endcase
      end else if (tick) begin
        phase_q <= phase_q + 2'd1;
        case (st_q)
          // Release SDA, raise SCL, pull SDA low, pull SCL low
          M_START: begin
            case (phase_q)
              2'd0: sda_oe_q <= 1'b0;
              2'd1: scl_oe_q <= 1'b0;
              2'd2: sda_oe_q <= 1'b1;
              default: begin
                scl_oe_q <= 1'b1;
                st_q <= M_IDLE;
                busy_q <= 1'b0;
              end
            endcase
          end
          // Data set while SCL low, sampled at SCL high
          M_BIT: begin
            case (phase_q)
              2'd0: sda_oe_q <= ~out_bit;
              2'd1: scl_oe_q <= 1'b0;
              2'd2: begin
                if (bit_q == 4'd8) begin
                  if (!rd_cmd) nack_q <= sda_sync_q[1];
                end else begin
                  rx_q <= {rx_q[6:0], sda_sync_q[1]};
                end
              end
              default: begin
                scl_oe_q <= 1'b1;
                bit_q <= bit_q + 4'd1;
                if (bit_q == 4'd8) begin
                  sda_oe_q <= 1'b0;
                  st_q <= M_IDLE;
                  busy_q <= 1'b0;
                end
              end
            endcase
          end
          // SDA low, raise SCL, release SDA
          M_STOP: begin
            case (phase_q)
              2'd0: sda_oe_q <= 1'b1;
              2'd1: scl_oe_q <= 1'b0;
              2'd2: sda_oe_q <= 1'b0;
              default: begin
                st_q <= M_IDLE;
                busy_q <= 1'b0;
              end
            endcase
          end
          default: st_q <= M_IDLE;
        endcase
      end
    end
  end

  assign link.scl_oe = scl_oe_q;
  assign link.sda_m_oe = sda_oe_q;
endmodule

// ---- i2c_link_asserts.sv ----
// Checker for the two-wire link between the master and slave ends.
// Assumes pclk oversamples SCL; sees only the interface signals.
`timescale 1ns/1ps
module i2c_link_asserts
  import i2c_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  // ------------------------------------------------------------
  // Bus event tracking
  // ------------------------------------------------------------
  logic scl_p, sda_p, busy_q, rd_q, nack_q, dat_q, own_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  // Edges and conditions seen at pclk
  wire rise_w = scl & ~scl_p;
  wire start_w = scl & scl_p & sda_p & ~sda;
  wire stop_w = scl & scl_p & ~sda_p & sda;
  wire ack_w = rise_w & (cnt_q == 4'h8);
  wire ours_w = (sh_q[7:1] == SLAVE_ADDR);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bit counter restarts on every START; SCL rise before a START is harmless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {scl_p, sda_p} <= 2'b11;
      {busy_q, rd_q, nack_q, dat_q, own_q} <= 5'h00;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
    end else begin
      {scl_p, sda_p} <= {scl, sda};
      if (start_w) begin
        {busy_q, rd_q, nack_q, dat_q, own_q} <= 5'h10;
        cnt_q <= 4'h0;
      end else if (stop_w) begin
        busy_q <= 1'b0;
      end else if (rise_w) begin
        cnt_q <= ack_w ? 4'h0 : cnt_q + 4'h1;
        if (!ack_w) sh_q <= {sh_q[6:0], sda};
        if (ack_w && !dat_q) {rd_q, own_q} <= {sh_q[0], ours_w};
        if (ack_w) dat_q <= 1'b1;
        if (ack_w && dat_q && rd_q && sda) nack_q <= 1'b1;
      end
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  AST_ADDR_IGNORED: assert property (ack_w && !dat_q && !ours_w && sh_q[7:1] != GCALL_ADDR |-> sda)
    else $error("slave answered a foreign address");
  AST_ADDR_ACK: assert property (ack_w && !dat_q && ours_w |-> !sda)
    else $error("own address not acknowledged");
  AST_WRITE_ACK: assert property (ack_w && dat_q && own_q && !rd_q |-> !sda)
    else $error("written byte not acknowledged");
  AST_IDLE_QUIET: assert property (!busy_q |-> !sda_s_oe)
    else $error("slave drives an idle bus");
  AST_SCL_LOW_CHANGE: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave moved SDA while SCL high");
  AST_NACK_ENDS: assert property (nack_q |-> !sda_s_oe)
    else $error("slave kept sending after not-acknowledge");
  AST_RESTART: assert property (start_w && busy_q |=> !sda_s_oe [*8])
    else $error("slave drove SDA after repeated start");
  AST_STOP_RELEASE: assert property (stop_w |=> !busy_q ##0 !sda_s_oe [*8])
    else $error("slave drove SDA after stop");
  AST_READ_DRIVE: assert property (rise_w && dat_q && rd_q && own_q && !nack_q && cnt_q != 4'h8
    |-> !sda_m_oe && sda == !sda_s_oe)
    else $error("read bit not driven by slave alone");
  // Main scenarios reached
  cover property (ack_w && dat_q && own_q && rd_q && !sda);
  cover property (start_w && busy_q);
  cover property (ack_w && !dat_q && sh_q[7:1] == GCALL_ADDR && !sda);
  cover property (nack_q);
endmodule

// ---- testbench.sv ----
// Testbench: APB drives the master end, which talks to the paged slave.
// Assumes package, link interface, both ends and checker compile first.
`timescale 1ns/1ps
module testbench;
  import i2c_port_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, st, rx;
  logic pready, pslverr, err, soft_reset_pulse_q, gcall_en_q, scl_p;
  logic [7:0] page_q;
  logic [8:0] mon_q;
  int errors = 0;
  int cmp_count = 0;
  int pulses = 0;
  i2c_link_if link ();
  i2c_bus_master i_i2c_bus_master (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link.master));
  i2c_paged_slave i_i2c_paged_slave (.pclk(pclk), .presetn(presetn), .link(link.slave),
    .page_q(page_q), .soft_reset_pulse_q(soft_reset_pulse_q), .gcall_en_q(gcall_en_q));
  i2c_link_asserts i_i2c_link_asserts (.pclk(pclk), .presetn(presetn), .scl_oe(link.scl_oe),
    .sda_m_oe(link.sda_m_oe), .sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda));
  always #2.5 pclk = ~pclk;
  // Wire monitor: last nine bits at SCL rises, plus reset pulse count
  always @(posedge pclk) begin
    scl_p <= link.scl;
    if (link.scl && !scl_p) mon_q <= {mon_q[7:0], link.sda};
    if (soft_reset_pulse_q === 1'b1) pulses <= pulses + 1;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tmo();
    errors++;
    $display("[FAIL] %0t wait limit reached", $time);
    end_of_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) tmo();
    rx = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Issue a command, poll busy, then fetch the received byte
  task automatic cmd(input cmd_t c, input logic [7:0] tx);
    int n;
    if (c == CMD_WRITE) apb(1'b1, OFF_TXDATA, {24'h00_0000, tx});
    apb(1'b1, OFF_CTRL, {29'h0000_0000, c});
    n = 0;
    do begin
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      n++;
    end while (rx[ST_BUSY] !== 1'b0 && n < 400);
    if (n >= 400) tmo();
    st = rx;
    apb(1'b0, OFF_RXDATA, 32'h0000_0000);
  endtask
  task automatic put(input logic [7:0] b, input logic nk);
    cmd(CMD_WRITE, b);
    chk(st[ST_NACK], nk);
    chk(mon_q, {b, nk});
  endtask
  task automatic get(input logic last, input logic [7:0] e);
    cmd(last ? CMD_READ_NACK : CMD_READ_ACK, 8'h00);
    chk(rx[7:0], e);
    chk(mon_q, {e, last});
  endtask
  task automatic probe(input logic [7:0] a, input logic nk);
    cmd(CMD_START, 8'h00);
    put(a, nk);
    cmd(CMD_STOP, 8'h00);
  endtask
  task automatic wr_reg(input logic [7:0] r, input logic [7:0] d);
    cmd(CMD_START, 8'h00);
    put({SLAVE_ADDR, 1'b0}, 1'b0);
    put(r, 1'b0);
    put(d, 1'b0);
    cmd(CMD_STOP, 8'h00);
    chk({link.scl, link.sda}, 2'b11);
  endtask
  // Pointer write, repeated start, then reads until the last byte
  task automatic rd_reg(input logic [7:0] r, input logic [7:0] e0, input logic [7:0] e1);
    cmd(CMD_START, 8'h00);
    put({SLAVE_ADDR, 1'b0}, 1'b0);
    put(r, 1'b0);
    cmd(CMD_START, 8'h00);
    put({SLAVE_ADDR, 1'b1}, 1'b0);
    get(1'b0, e0);
    get(1'b1, e1);
    cmd(CMD_STOP, 8'h00);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk(page_q, 32'h0000_0000);
    chk(gcall_en_q, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(err, 32'h0000_0001);
  endtask
  task automatic t_addr();
    logic [7:0] miss [3] = '{8'h32, 8'h10, 8'hB1};
    foreach (miss[i]) probe(miss[i], 1'b1);
    probe(8'h00, 1'b1);
    wr_reg({1'b0, REG_GCALL}, 8'h20);
    chk(gcall_en_q, 32'h0000_0001);
    probe(8'h00, 1'b0);
  endtask
  // Auto-increment on both writes and reads, registers 5 and 6
  task automatic t_burst();
    cmd(CMD_START, 8'h00);
    put({SLAVE_ADDR, 1'b0}, 1'b0);
    put(8'h05, 1'b0);
    put(8'hA5, 1'b0);
    put(8'h3C, 1'b0);
    cmd(CMD_STOP, 8'h00);
    rd_reg(8'h05, 8'hA5, 8'h3C);
  endtask
  // Page select holds a usable page byte; then the self-clearing reset
  task automatic t_page_reset();
    wr_reg({1'b0, REG_PAGE}, 8'h5F);
    chk(page_q, 32'h0000_005F);
    rd_reg({1'b0, REG_PAGE}, 8'h5F, REG_RST);
    wr_reg({1'b0, REG_PAGE}, PAGE_RST);
    chk(page_q, 32'h0000_0000);
    wr_reg({1'b0, REG_SWRST}, 8'h00);
    chk(pulses, 32'h0000_0000);
    rd_reg(8'h05, 8'hA5, 8'h3C);
    wr_reg({1'b0, REG_SWRST}, 8'h01);
    chk(pulses, 32'h0000_0001);
    rd_reg({1'b0, REG_PAGE}, PAGE_RST, REG_RST);
    rd_reg(8'h05, REG_RST, REG_RST);
    chk(gcall_en_q, 32'h0000_0000);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_addr();
    t_burst();
    t_page_reset();
    end_of_test();
  end
endmodule
